/* File: logic/misc_regs_pkg.sv */
// Constants for the miscellaneous timer, pin and switch register group
package misc_regs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CI_IND_IN   = 8'h31;
   localparam logic [7:0] OFS_CI_CMD_OUT  = 8'h32;
   localparam logic [7:0] OFS_GCI_EVENTS  = 8'h34;
   localparam logic [7:0] OFS_GCI_MASK    = 8'h35;
   localparam logic [7:0] OFS_TENTH_TIMER = 8'h38;
   localparam logic [7:0] OFS_MS_TIMER    = 8'h39;
   localparam logic [7:0] OFS_PIN_DIR     = 8'h3a;
   localparam logic [7:0] OFS_PIN_DATA    = 8'h3b;
   localparam logic [7:0] OFS_SWITCH_CTRL = 8'h3c;
   localparam logic [7:0] OFS_AUX_ONE     = 8'h3d;

   // Reset values
   localparam logic [5:0] RST_CI_CMD  = 6'h3f;
   localparam logic [7:0] RST_MASK    = 8'hf7;
   localparam logic [7:0] RST_ZERO    = 8'h00;

   // Event register and mask field positions
   localparam int EV_CI_CHANGE = 0;
   localparam int EV_MON_ZERO  = 3;
   localparam int EV_MON_ONE   = 4;
   localparam logic [7:0] MASK_FIXED_ONES = 8'he0;
   localparam logic [7:0] EVENT_BITS      = 8'h19;
   localparam int MASK_SPARE_LSB          = 1;

   // Timer register fields
   localparam int TMR_MODE_BIT  = 7;
   localparam int TMR_IDLE_BIT  = 6;

   // Switch control fields
   localparam int SW_BUS_SEL    = 6;
   localparam int SW_REM_LOOP   = 5;
   localparam int SW_CROSS      = 4;
   localparam int SW_B2_LSB     = 2;
   localparam int SW_B1_LSB     = 0;
   localparam logic [1:0] BSW_L2_L1  = 2'h0;
   localparam logic [1:0] BSW_L1_PCM = 2'h1;
   localparam logic [1:0] BSW_PCM_L2 = 2'h2;

   // Aux control one fields
   localparam int AUX_SOFT_RESET_BIT_BIT  = 5;
   localparam int AUX_PD_BIT    = 2;

   // Timing
   localparam int CLK_HZ          = 125_000_000;
   localparam int HALF_MS_US      = 500;
   localparam int HALF_MS_CYCLES  = CLK_HZ / 1_000_000 * HALF_MS_US;
   localparam int SOFT_RESET_BIT_HOLD_MS    = 1;
   localparam int SOFT_RESET_BIT_HOLD_CYCLES = CLK_HZ / 1000 * SOFT_RESET_BIT_HOLD_MS;
   localparam int TENTH_S_MS      = 100;
   localparam logic [7:0] HALF_MS_PER_TENTH = 8'(2 * TENTH_S_MS);
endpackage

/* File: logic/misc_timer_switch_regs.sv */
// Miscellaneous GCI event, timer, pin and switch register group
// Overview of operation
// RL1: CI command register drives six-bit CI1 code, resets to ones, reads back.
// RL2: Received CI1 code readable; any change flags an event, TE mode only.
// RL3: Monitor channel 1 or 0 status change sets event bit 4 or 3.
// RL4: Mask bit set disables event; bits 7-5 read one, bit 3 zero.
// RL5: Tenth-second timer stops after one expiry or repeats, by mode bit.
// RL6: Tenth-second expiry interval is count field times 0.1 s.
// RL7: Host starts timer via start bit; reads then give current count.
// RL8: Host adds clock-enable command when layer 1 is not active.
// RL9: Tenth-second timer stops at single expiry and on any rewrite.
// RL10: Millisecond timer starts on nonzero write, 1-63 ms, event at zero.
// RL11: Wave pin goes high on start, toggles every half count.
// RL12: Millisecond timer stops at single expiry or zero write; pin idles.
// RL13: Direction bit 0 makes a pin input, 1 drives it.
// RL14: Pin data reads live pin levels; written bits drive output pins.
// RL15: Upper two pins act as interrupt inputs unless mode bits cleared.
// RL16: Bus select bit routes codec to PCM when 1, GCI when 0.
// RL17: Remote loopback returns transmitted PCM data into received PCM.
// RL18: Cross-connect pairs PCM ports straight when 0, swapped when 1.
// RL19: B switch codes 00, 01, 10 select the three channel paths.
// RL20: Soft reset held 1 ms resets like hardware; accesses inhibited. Code still accepts writes to aux control one during it.
// RL21: Power-down enable resets to 0; when set, idle line powers down.
// RL22: Reading the event register clears the bits it returned.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module misc_timer_switch_regs
   import misc_regs_pkg::*;
#(
   parameter int HALF_MS_COUNT = HALF_MS_CYCLES,
   parameter int SOFT_RESET_BIT_HOLD     = SOFT_RESET_BIT_HOLD_CYCLES,
   parameter int PCM_WIDTH     = 8
) (
   input  wire logic                 CLK_SYS,
   input  wire logic                 SYS_RST,
   input  wire logic [7:0]           ADR_I,
   input  wire logic [7:0]           DAT_I,
   output logic      [7:0]           DAT_O,
   input  wire logic                 WE_I,
   input  wire logic                 CYC_I,
   input  wire logic                 STB_I,
   output logic                      ACK_O,
   input  wire logic                 TE_MODE,
   input  wire logic [5:0]           CI_IND_IN,
   output logic      [5:0]           CI_CMD_OUT,
   input  wire logic                 MON_ONE_CHANGE,
   input  wire logic                 MON_ZERO_CHANGE,
   output logic                      GCI_EVENT_IRQ,
   input  wire logic                 SLOW_TIMER_START,
   output logic                      SLOW_TIMER_EXPIRY,
   output logic                      FAST_TIMER_EVENT,
   output logic                      TIMER_WAVE_PIN,
   input  wire logic [3:0]           GP_PIN_IN,
   output logic      [3:0]           GP_PIN_OUT,
   output logic      [3:0]           GP_PIN_OE_N,
   input  wire logic [1:0]           EXT_INT_MODE,
   output logic                      CODEC_BUS_SELECT,
   output logic                      PCM_CROSS_CONNECT,
   output logic      [1:0]           B1_SWITCH_FIELD,
   output logic      [1:0]           B2_SWITCH_FIELD,
   input  wire logic [PCM_WIDTH-1:0] PCM_TX_DATA,
   input  wire logic [PCM_WIDTH-1:0] PCM_LINE_RX,
   output logic      [PCM_WIDTH-1:0] PCM_RX_DATA,
   input  wire logic                 LINE_INFO0_ONLY,
   output logic                      POWER_DOWN,
   output logic                      SOFT_RESET_ACTIVE
);

   // Effective mask: bits 7-5 one, bit 3 zero so monitor zero stays unmaskable
   function automatic logic [7:0] mask_view(input logic m_one, input logic [1:0] m_spare, input logic m_ci);
      mask_view = MASK_FIXED_ONES;
      mask_view[EV_MON_ONE] = m_one;
      mask_view[MASK_SPARE_LSB +: 2] = m_spare;
      mask_view[EV_CI_CHANGE] = m_ci;
   endfunction

   logic        ack_reg;
   logic [7:0]  dat_reg;
   logic        access;
   logic        wr_ok;
   logic        rd_ok;
   logic        soft_reset_bit_reg;
   logic [31:0] soft_reset_bit_cnt_reg;
   logic        core_rst;
   logic        pd_reg;
   logic [5:0]  ci_cmd_reg;
   logic [5:0]  ci_seen_reg;
   logic [7:0]  events_reg;
   logic [7:0]  events_next;
   logic        mask_one_reg;
   logic        mask_ci_reg;
   logic [1:0]  mask_spare_reg;
   logic [7:0]  slow_cfg_reg;
   logic [6:0]  slow_cur_reg;
   logic        slow_run_reg;
   logic        slow_started_reg;
   logic [7:0]  tenth_cnt_reg;
   logic [7:0]  fast_cfg_reg;
   logic        fast_run_reg;
   logic [5:0]  fast_ph_reg;
   logic        fast_half_reg;
   logic        wave_reg;
   logic [31:0] half_ms_cnt_reg;
   logic        half_ms_tick;
   logic [3:0]  dir_reg;
   logic [3:0]  pin_data_reg;
   logic [6:0]  switch_reg;
   logic [7:0]  rd_data;

   // Slave acknowledges one cycle after the strobe; writes land on that edge
   assign access = CYC_I & STB_I & ~ack_reg;
   assign wr_ok  = access & WE_I & (~soft_reset_bit_reg | (ADR_I == OFS_AUX_ONE)); // RL20
   assign rd_ok  = access & ~WE_I & ~soft_reset_bit_reg; // RL20

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ack_reg <= 1'b0;
         dat_reg <= RST_ZERO;
      end else begin
         ack_reg <= access;
         if (access) begin
            dat_reg <= rd_ok ? rd_data : RST_ZERO;
         end
      end
   end

   assign ACK_O = ack_reg;
   assign DAT_O = dat_reg;

   // Soft reset bit survives its own reset; only the host or the pin clears it
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         soft_reset_bit_reg     <= 1'b0;
         soft_reset_bit_cnt_reg <= '0;
         core_rst     <= 1'b0;
      end else begin
         if (wr_ok && ADR_I == OFS_AUX_ONE) begin
            soft_reset_bit_reg <= DAT_I[AUX_SOFT_RESET_BIT_BIT];
         end
         if (!soft_reset_bit_reg) begin
            soft_reset_bit_cnt_reg <= '0;
            core_rst     <= 1'b0;
         end else if (soft_reset_bit_cnt_reg >= 32'(SOFT_RESET_BIT_HOLD - 1)) begin
            core_rst <= 1'b1; // RL20
         end else begin
            soft_reset_bit_cnt_reg <= soft_reset_bit_cnt_reg + 32'd1;
         end
      end
   end

   assign SOFT_RESET_ACTIVE = core_rst;

   // Shared half-millisecond time base
   // Free-running, so a timer's first tick may come up to half a ms early
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || core_rst) begin
         half_ms_cnt_reg <= '0;
         half_ms_tick    <= 1'b0;
      end else if (half_ms_cnt_reg >= 32'(HALF_MS_COUNT - 1)) begin
         half_ms_cnt_reg <= '0;
         half_ms_tick    <= 1'b1;
      end else begin
         half_ms_cnt_reg <= half_ms_cnt_reg + 32'd1;
         half_ms_tick    <= 1'b0;
      end
   end

   // CI command and received code watch
   // Seen code tracks the input through reset, so release flags no false change
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || core_rst) begin
         ci_cmd_reg  <= RST_CI_CMD; // RL1
         ci_seen_reg <= CI_IND_IN;
      end else begin
         if (wr_ok && ADR_I == OFS_CI_CMD_OUT) begin
            ci_cmd_reg <= DAT_I[5:0]; // RL1
         end
         ci_seen_reg <= CI_IND_IN;
      end
   end

   assign CI_CMD_OUT = ci_cmd_reg;

   // Event flags: new events beat the read clear in the same cycle
   always_comb begin
      events_next = events_reg;
      if (rd_ok && ADR_I == OFS_GCI_EVENTS) begin
         events_next = RST_ZERO; // RL22
      end
      if (TE_MODE && CI_IND_IN != ci_seen_reg) begin
         events_next[EV_CI_CHANGE] = 1'b1; // RL2
      end
      if (MON_ZERO_CHANGE) begin
         events_next[EV_MON_ZERO] = 1'b1; // RL3
      end
      if (MON_ONE_CHANGE) begin
         events_next[EV_MON_ONE] = 1'b1; // RL3
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || core_rst) begin
         events_reg    <= RST_ZERO;
         GCI_EVENT_IRQ <= 1'b0;
      end else begin
         events_reg    <= events_next & EVENT_BITS;
         GCI_EVENT_IRQ <= |(events_next & EVENT_BITS & ~mask_view(mask_one_reg, mask_spare_reg, mask_ci_reg)); // RL4
      end
   end

   // Mask bits 2-1 gate no event but keep their reset ones for software
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || core_rst) begin
         mask_one_reg   <= RST_MASK[EV_MON_ONE];
         mask_spare_reg <= RST_MASK[MASK_SPARE_LSB +: 2];
         mask_ci_reg    <= RST_MASK[EV_CI_CHANGE];
      end else if (wr_ok && ADR_I == OFS_GCI_MASK) begin
         mask_one_reg   <= DAT_I[EV_MON_ONE]; // RL4
         mask_spare_reg <= DAT_I[MASK_SPARE_LSB +: 2];
         mask_ci_reg    <= DAT_I[EV_CI_CHANGE];
      end
   end

   // Tenth-second timer, ticking every 200 half-millisecond ticks
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || core_rst) begin
         slow_cfg_reg      <= RST_ZERO;
         slow_cur_reg      <= '0;
         slow_run_reg      <= 1'b0;
         slow_started_reg  <= 1'b0;
         tenth_cnt_reg     <= '0;
         SLOW_TIMER_EXPIRY <= 1'b0;
      end else begin
         SLOW_TIMER_EXPIRY <= 1'b0;
         if (wr_ok && ADR_I == OFS_TENTH_TIMER) begin
            slow_cfg_reg     <= DAT_I;
            slow_run_reg     <= 1'b0; // RL9
            slow_started_reg <= 1'b0;
         end else if (SLOW_TIMER_START && slow_cfg_reg[6:0] != 7'h00) begin
            // Start request arrives only once clocks run on the line side
            slow_cur_reg     <= slow_cfg_reg[6:0]; // RL7 RL8
            slow_run_reg     <= 1'b1;
            slow_started_reg <= 1'b1;
            tenth_cnt_reg    <= '0;
         end else if (slow_run_reg && half_ms_tick) begin
            if (tenth_cnt_reg == HALF_MS_PER_TENTH - 8'd1) begin
               tenth_cnt_reg <= '0;
               if (slow_cur_reg == 7'd1) begin
                  SLOW_TIMER_EXPIRY <= 1'b1; // RL6
                  slow_cur_reg      <= slow_cfg_reg[6:0];
                  slow_run_reg      <= slow_cfg_reg[TMR_MODE_BIT]; // RL5 RL9
               end else begin
                  slow_cur_reg <= slow_cur_reg - 7'd1;
               end
            end else begin
               tenth_cnt_reg <= tenth_cnt_reg + 8'd1;
            end
         end
      end
   end

   // Millisecond timer: each half of the wave lasts count half-milliseconds
   // A rewrite before expiry restarts the count with the new value
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || core_rst) begin
         fast_cfg_reg     <= RST_ZERO;
         fast_run_reg     <= 1'b0;
         fast_ph_reg      <= '0;
         fast_half_reg    <= 1'b0;
         wave_reg         <= 1'b0;
         FAST_TIMER_EVENT <= 1'b0;
      end else begin
         FAST_TIMER_EVENT <= 1'b0;
         if (wr_ok && ADR_I == OFS_MS_TIMER) begin
            fast_cfg_reg  <= DAT_I;
            fast_run_reg  <= DAT_I[5:0] != 6'h00; // RL10 RL12
            fast_ph_reg   <= '0;
            fast_half_reg <= 1'b0;
            wave_reg      <= (DAT_I[5:0] != 6'h00) ? 1'b1 : DAT_I[TMR_IDLE_BIT]; // RL11 RL12
         end else if (!fast_run_reg) begin
            wave_reg <= fast_cfg_reg[TMR_IDLE_BIT]; // RL12
         end else if (half_ms_tick) begin
            if (fast_ph_reg == fast_cfg_reg[5:0] - 6'd1) begin
               fast_ph_reg   <= '0;
               fast_half_reg <= ~fast_half_reg;
               wave_reg      <= ~wave_reg; // RL11
               if (fast_half_reg) begin
                  FAST_TIMER_EVENT <= 1'b1; // RL10
                  if (!fast_cfg_reg[TMR_MODE_BIT]) begin
                     fast_run_reg <= 1'b0; // RL12
                     wave_reg     <= fast_cfg_reg[TMR_IDLE_BIT];
                  end
               end
            end else begin
               fast_ph_reg <= fast_ph_reg + 6'd1;
            end
         end
      end
   end

   assign TIMER_WAVE_PIN = wave_reg;

   // General-purpose pins; upper two yield to interrupt mode
   // Drive and enables come from flops, so a write never glitches a pin
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || core_rst) begin
         dir_reg      <= '0;
         pin_data_reg <= '0;
         GP_PIN_OUT   <= '0;
         GP_PIN_OE_N  <= 4'hf;
      end else begin
         if (wr_ok && ADR_I == OFS_PIN_DIR) begin
            dir_reg <= DAT_I[3:0];
         end
         if (wr_ok && ADR_I == OFS_PIN_DATA) begin
            pin_data_reg <= DAT_I[3:0];
         end
         GP_PIN_OUT  <= pin_data_reg; // RL14
         GP_PIN_OE_N <= ~(dir_reg & {~EXT_INT_MODE, 2'b11}); // RL13 RL15
      end
   end

   // Channel switching and PCM loopback
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || core_rst) begin
         switch_reg  <= '0;
         PCM_RX_DATA <= '0;
      end else begin
         if (wr_ok && ADR_I == OFS_SWITCH_CTRL) begin
            switch_reg <= DAT_I[6:0];
         end
         PCM_RX_DATA <= switch_reg[SW_REM_LOOP] ? PCM_TX_DATA : PCM_LINE_RX; // RL17
      end
   end

   assign CODEC_BUS_SELECT  = switch_reg[SW_BUS_SEL]; // RL16
   assign PCM_CROSS_CONNECT = switch_reg[SW_CROSS]; // RL18
   assign B1_SWITCH_FIELD   = switch_reg[SW_B1_LSB +: 2]; // RL19
   assign B2_SWITCH_FIELD   = switch_reg[SW_B2_LSB +: 2]; // RL19

   // Power-down enable; a soft reset clears it like the pin
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || core_rst) begin
         pd_reg     <= 1'b0; // RL21
         POWER_DOWN <= 1'b0;
      end else begin
         if (wr_ok && ADR_I == OFS_AUX_ONE) begin
            pd_reg <= DAT_I[AUX_PD_BIT];
         end
         POWER_DOWN <= pd_reg & LINE_INFO0_ONLY; // RL21
      end
   end

   // Read multiplexer
   // Unmapped offsets read zero
   always_comb begin
      rd_data = RST_ZERO;
      unique case (ADR_I)
         OFS_CI_IND_IN:   rd_data = {2'b00, CI_IND_IN}; // RL2
         OFS_CI_CMD_OUT:  rd_data = {2'b00, ci_cmd_reg}; // RL1
         OFS_GCI_EVENTS:  rd_data = events_reg; // RL22
         OFS_GCI_MASK:    rd_data = mask_view(mask_one_reg, mask_spare_reg, mask_ci_reg); // RL4
         OFS_TENTH_TIMER: rd_data = slow_started_reg ?
                                    {slow_cfg_reg[TMR_MODE_BIT], slow_cur_reg} : slow_cfg_reg; // RL7
         OFS_MS_TIMER:    rd_data = fast_cfg_reg;
         OFS_PIN_DIR:     rd_data = {4'h0, dir_reg};
         OFS_PIN_DATA:    rd_data = {4'h0, GP_PIN_IN}; // RL14
         OFS_SWITCH_CTRL: rd_data = {1'b0, switch_reg};
         OFS_AUX_ONE:     rd_data = {2'b00, soft_reset_bit_reg, 2'b00, pd_reg, 2'b00};
         default:         rd_data = RST_ZERO;
      endcase
   end

endmodule

/* File: verif/misc_timer_switch_regs_monitor.sv */
// Concurrent checks on the register group ports
`timescale 1ns/1ps
module misc_timer_switch_regs_monitor
   import misc_regs_pkg::*;
(
   input wire logic       CLK_SYS,
   input wire logic       SYS_RST,
   input wire logic [7:0] ADR_I,
   input wire logic [7:0] DAT_I,
   input wire logic [7:0] DAT_O,
   input wire logic       WE_I,
   input wire logic       CYC_I,
   input wire logic       STB_I,
   input wire logic       ACK_O,
   input wire logic       MON_ZERO_CHANGE,
   input wire logic       GCI_EVENT_IRQ,
   input wire logic [5:0] CI_CMD_OUT,
   input wire logic [1:0] EXT_INT_MODE,
   input wire logic [3:0] GP_PIN_OE_N,
   input wire logic       CODEC_BUS_SELECT,
   input wire logic       PCM_CROSS_CONNECT,
   input wire logic [1:0] B1_SWITCH_FIELD,
   input wire logic [1:0] B2_SWITCH_FIELD,
   input wire logic       TIMER_WAVE_PIN,
   input wire logic       LINE_INFO0_ONLY,
   input wire logic       POWER_DOWN
);
   logic soft_reset_bit_reg;
   logic take;
   logic wr_ok;
   logic rd_ev;
   assign take = CYC_I & STB_I & ~ACK_O;
   assign wr_ok = take & WE_I & ~soft_reset_bit_reg;
   assign rd_ev = take & ~WE_I & (ADR_I == OFS_GCI_EVENTS);
   // Shadow of the soft reset bit, accesses under it are inhibited
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         soft_reset_bit_reg <= 1'b0;
      end else if (take && WE_I && ADR_I == OFS_AUX_ONE) begin
         soft_reset_bit_reg <= DAT_I[AUX_SOFT_RESET_BIT_BIT];
      end
   end
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);
   chk_ack_single_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
   chk_ci_reset_ones: assert property ($fell(SYS_RST) |-> CI_CMD_OUT == RST_CI_CMD)
      else $error("ci command not ones after reset");
   chk_ci_write_echo: assert property (wr_ok && ADR_I == OFS_CI_CMD_OUT |=> CI_CMD_OUT == $past(DAT_I[5:0]))
      else $error("ci command pins differ from write");
   chk_mask_fixed_bits: assert property (take && !WE_I && !soft_reset_bit_reg && ADR_I == OFS_GCI_MASK
      |=> DAT_O[7:5] == 3'h7 && !DAT_O[3]) else $error("mask fixed bits wrong");
   chk_mon_zero_irq: assert property (MON_ZERO_CHANGE && !soft_reset_bit_reg ##1 !rd_ev [*2] |-> GCI_EVENT_IRQ)
      else $error("monitor zero event not signalled");
   chk_int_pin_free: assert property ((EXT_INT_MODE & $past(EXT_INT_MODE)) != 2'b00
      |-> (GP_PIN_OE_N[3:2] | ~(EXT_INT_MODE & $past(EXT_INT_MODE))) == 2'b11) else $error("interrupt pin driven");
   chk_switch_fields: assert property (wr_ok && ADR_I == OFS_SWITCH_CTRL |=>
      {CODEC_BUS_SELECT, PCM_CROSS_CONNECT, B2_SWITCH_FIELD, B1_SWITCH_FIELD} == {$past(DAT_I[6]), $past(DAT_I[4:0])})
      else $error("switch outputs differ from write");
   chk_wave_start_high: assert property (wr_ok && ADR_I == OFS_MS_TIMER && DAT_I[5:0] != 6'h00
      |-> ##[1:2] TIMER_WAVE_PIN) else $error("wave pin not high at start");
   chk_wave_idle_level: assert property (wr_ok && ADR_I == OFS_MS_TIMER && DAT_I[5:0] == 6'h00
      |=> ##1 TIMER_WAVE_PIN == $past(DAT_I[6], 2)) else $error("wave pin not at idle level");
   chk_power_down_lag: assert property (POWER_DOWN |-> $past(LINE_INFO0_ONLY))
      else $error("power down without idle line");
endmodule
bind misc_timer_switch_regs misc_timer_switch_regs_monitor mon (.CLK_SYS, .SYS_RST, .ADR_I, .DAT_I, .DAT_O, .WE_I,
   .CYC_I, .STB_I, .ACK_O, .MON_ZERO_CHANGE, .GCI_EVENT_IRQ, .CI_CMD_OUT, .EXT_INT_MODE, .GP_PIN_OE_N,
   .CODEC_BUS_SELECT, .PCM_CROSS_CONNECT, .B1_SWITCH_FIELD, .B2_SWITCH_FIELD, .TIMER_WAVE_PIN, .LINE_INFO0_ONLY,
   .POWER_DOWN);

/* File: verif/test_misc_timer_switch_regs.sv */
// Self-checking bench for the register group
`timescale 1ns/1ps
module test_misc_timer_switch_regs
   import misc_regs_pkg::*;
;
   logic       CLK_SYS = 1'b0, SYS_RST = 1'b1, WE_I = 1'b0, CYC_I = 1'b0, STB_I = 1'b0, TE_MODE = 1'b1;
   logic       MON_ONE_CHANGE = 1'b0, MON_ZERO_CHANGE = 1'b0, SLOW_TIMER_START = 1'b0, LINE_INFO0_ONLY = 1'b0;
   logic [7:0] ADR_I = 8'h00, DAT_I = 8'h00, PCM_TX_DATA = 8'h00, PCM_LINE_RX = 8'h00;
   logic [5:0] CI_IND_IN = 6'h00;
   logic [3:0] GP_PIN_IN = 4'h0;
   logic [1:0] EXT_INT_MODE = 2'h0;
   logic       ACK_O, GCI_EVENT_IRQ, SLOW_TIMER_EXPIRY, FAST_TIMER_EVENT, TIMER_WAVE_PIN, CODEC_BUS_SELECT;
   logic       PCM_CROSS_CONNECT, POWER_DOWN, SOFT_RESET_ACTIVE;
   logic [7:0] DAT_O, PCM_RX_DATA, d;
   logic [5:0] CI_CMD_OUT, c;
   logic [3:0] GP_PIN_OUT, GP_PIN_OE_N;
   logic [1:0] B1_SWITCH_FIELD, B2_SWITCH_FIELD;
   logic [7:0] expq[$];
   logic [7:0] radr[10] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h38, 8'h39, 8'h3a, 8'h3c, 8'h3d};
   logic [7:0] rval[10] = '{8'h00, 8'h3f, 8'h00, 8'h00, 8'hf7, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   int         failures = 0, cmp_count = 0, cyc_n = 0, sev = 0, fev = 0, slast = 0, t0, t1, n;

   misc_timer_switch_regs #(.HALF_MS_COUNT(4), .SOFT_RESET_BIT_HOLD(8)) uut (.CLK_SYS, .SYS_RST, .ADR_I, .DAT_I, .DAT_O,
      .WE_I, .CYC_I, .STB_I, .ACK_O, .TE_MODE, .CI_IND_IN, .CI_CMD_OUT, .MON_ONE_CHANGE, .MON_ZERO_CHANGE,
      .GCI_EVENT_IRQ, .SLOW_TIMER_START, .SLOW_TIMER_EXPIRY, .FAST_TIMER_EVENT, .TIMER_WAVE_PIN, .GP_PIN_IN,
      .GP_PIN_OUT, .GP_PIN_OE_N, .EXT_INT_MODE, .CODEC_BUS_SELECT, .PCM_CROSS_CONNECT, .B1_SWITCH_FIELD,
      .B2_SWITCH_FIELD, .PCM_TX_DATA, .PCM_LINE_RX, .PCM_RX_DATA, .LINE_INFO0_ONLY, .POWER_DOWN,
      .SOFT_RESET_ACTIVE);

   initial begin
      forever #4 CLK_SYS = ~CLK_SYS;
   end

   always @(posedge CLK_SYS) begin
      cyc_n <= cyc_n + 1;
      if (SLOW_TIMER_EXPIRY === 1'b1) begin
         sev <= sev + 1;
         slast <= cyc_n;
      end
      if (FAST_TIMER_EVENT === 1'b1) begin
         fev <= fev + 1;
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Read results are paired with the oldest note when the ack shows up
   always @(posedge CLK_SYS) begin
      if (ACK_O === 1'b1 && WE_I === 1'b0 && expq.size() > 0) begin
         check("read data", DAT_O, expq.pop_front());
      end
   end

   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] wd, input logic [7:0] e = 8'h00);
      int k;
      k = 0;
      @(posedge CLK_SYS);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      ADR_I <= a;
      WE_I <= w;
      DAT_I <= wd;
      if (!w) expq.push_back(e);
      do begin
         @(posedge CLK_SYS);
         k++;
      end while (ACK_O !== 1'b1 && k < 20);
      if (ACK_O !== 1'b1) failures++;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      @(negedge CLK_SYS);
   endtask

   task automatic mon_pulse(input logic [1:0] m);
      @(posedge CLK_SYS);
      {MON_ONE_CHANGE, MON_ZERO_CHANGE} <= m;
      @(posedge CLK_SYS);
      {MON_ONE_CHANGE, MON_ZERO_CHANGE} <= 2'b00;
   endtask

   task automatic slow_start();
      @(posedge CLK_SYS);
      SLOW_TIMER_START <= 1'b1;
      @(posedge CLK_SYS);
      SLOW_TIMER_START <= 1'b0;
   endtask

   // Detection lags the event by a fixed cycle, so differences stay exact
   task automatic wait_fast(output int t);
      int n0;
      n0 = fev;
      repeat (200) begin
         if (fev != n0) break;
         @(posedge CLK_SYS);
      end
      t = cyc_n;
   endtask

   task automatic report_and_stop();
      if (failures == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge CLK_SYS);
      failures++;
      report_and_stop();
   end

   initial begin
      void'($urandom(12));
      repeat (5) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      foreach (radr[i]) begin
         wb(radr[i], 1'b0, 8'h00, rval[i]);
      end
      d = 8'($urandom);
      wb(8'h32, 1'b1, d);
      wb(8'h32, 1'b0, 8'h00, {2'b00, d[5:0]});
      check("ci command pins", CI_CMD_OUT, d[5:0]);
      c = 6'($urandom) | 6'h01;
      @(posedge CLK_SYS);
      CI_IND_IN <= c;
      mon_pulse(2'b11);
      wb(8'h31, 1'b0, 8'h00, {2'b00, c});
      wb(8'h34, 1'b0, 8'h00, 8'h19);
      wb(8'h34, 1'b0, 8'h00, 8'h00);
      @(posedge CLK_SYS);
      TE_MODE <= 1'b0;
      CI_IND_IN <= ~c;
      wb(8'h34, 1'b0, 8'h00, 8'h00);
      wb(8'h35, 1'b1, 8'hff);
      wb(8'h35, 1'b0, 8'h00, 8'hf7);
      mon_pulse(2'b10);
      repeat (3) @(posedge CLK_SYS);
      check("event line masked", GCI_EVENT_IRQ, 8'h00);
      mon_pulse(2'b01);
      repeat (3) @(posedge CLK_SYS);
      check("event line unmaskable", GCI_EVENT_IRQ, 8'h01);
      wb(8'h34, 1'b0, 8'h00, 8'h18);
      wb(8'h35, 1'b1, 8'h00);
      wb(8'h35, 1'b0, 8'h00, 8'he0);
      wb(8'h3a, 1'b1, 8'h05);
      wb(8'h3b, 1'b1, 8'h05);
      check("pin enables", GP_PIN_OE_N, 4'ha);
      check("pin drive", GP_PIN_OUT & ~GP_PIN_OE_N, 4'h5);
      d = 8'($urandom);
      @(posedge CLK_SYS);
      GP_PIN_IN <= d[3:0];
      EXT_INT_MODE <= 2'b01;
      wb(8'h3b, 1'b0, 8'h00, {4'h0, d[3:0]});
      check("interrupt pin released", GP_PIN_OE_N, 4'he);
      for (int i = 0; i < 4; i++) begin
         d = {1'b0, i[0], i[1], i[0], i[1:0], ~i[1:0]};
         @(posedge CLK_SYS);
         PCM_TX_DATA <= 8'($urandom);
         PCM_LINE_RX <= 8'($urandom);
         wb(8'h3c, 1'b1, d);
         check("switch pins", {CODEC_BUS_SELECT, PCM_CROSS_CONNECT, B2_SWITCH_FIELD, B1_SWITCH_FIELD}, {d[6], d[4:0]});
         check("pcm receive", PCM_RX_DATA, d[5] ? PCM_TX_DATA : PCM_LINE_RX);
      end
      @(posedge CLK_SYS);
      LINE_INFO0_ONLY <= 1'b1;
      wb(8'h3d, 1'b1, 8'h04);
      check("power down", POWER_DOWN, 8'h01);
      wb(8'h3d, 1'b1, 8'h24);
      check("soft reset early", SOFT_RESET_ACTIVE, 8'h00);
      repeat (12) @(posedge CLK_SYS);
      check("soft reset", SOFT_RESET_ACTIVE, 8'h01);
      wb(8'h32, 1'b0, 8'h00, 8'h00);
      wb(8'h3d, 1'b1, 8'h00);
      wb(8'h32, 1'b0, 8'h00, 8'h3f);
      wb(8'h3d, 1'b0, 8'h00, 8'h00);
      wb(8'h39, 1'b1, 8'h83);
      check("wave at start", TIMER_WAVE_PIN, 8'h01);
      wait_fast(t0);
      wait_fast(t1);
      check("ms period", 8'(t1 - t0), 8'd24);
      wb(8'h39, 1'b1, 8'h40);
      n = fev;
      repeat (60) @(posedge CLK_SYS);
      check("ms stopped", 8'(fev - n), 8'h00);
      check("wave idle high", TIMER_WAVE_PIN, 8'h01);
      wb(8'h39, 1'b1, 8'h02);
      n = fev;
      repeat (60) @(posedge CLK_SYS);
      check("ms single", 8'(fev - n), 8'h01);
      check("wave idle low", TIMER_WAVE_PIN, 8'h00);
      wb(8'h38, 1'b1, 8'h02);
      slow_start();
      t0 = cyc_n;
      n = sev;
      wb(8'h38, 1'b0, 8'h00, 8'h02);
      repeat (3400) @(posedge CLK_SYS);
      check("slow single", 8'(sev - n), 8'h01);
      check("slow interval", 8'((slast - t0 + 8) / 16), 8'd100);
      wb(8'h38, 1'b1, 8'h81);
      slow_start();
      n = sev;
      repeat (1900) @(posedge CLK_SYS);
      check("slow periodic", 8'(sev - n), 8'h02);
      wb(8'h38, 1'b1, 8'h81);
      n = sev;
      repeat (1000) @(posedge CLK_SYS);
      check("slow rewrite stops", 8'(sev - n), 8'h00);
      report_and_stop();
   end
endmodule
